/* File: hw/usbf_iso_ctrl.sv */
// Added by the designer: the register addresses and the APB register port.
module usbf_iso_ctrl #(
  parameter int SUSP_CYCLES = usbf_pkg::SUSP_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire usbf_pkg::usbf_token_t token,
  input  wire usbf_pkg::usbf_rx_t    rx,
  output usbf_pkg::usbf_tx_t         tx,
  input  wire logic               tx_ready,
  input  wire logic               bus_active,
  input  wire logic               bus_reset,
  output logic                    evt_suspend,
  output logic                    evt_resume,
  output logic                    evt_bus_reset,
  input  wire logic               frame_gpio_o,
  input  wire logic               frame_gpio_oe,
  output logic                    frame_pulse_pin_o,
  output logic                    frame_pulse_pin_oe,
  input  wire logic               pullup_gpio_o,
  input  wire logic               pullup_gpio_oe,
  output logic                    pullup_supply_pin_o,
  output logic                    pullup_supply_pin_oe,
  input  wire logic               bus_power_sense_pin,
  output logic                    vbus_present
);
  localparam int PW = $clog2(usbf_pkg::BUF_DEPTH) + 1;
  localparam logic [PW-1:0] DEPTH = PW'(usbf_pkg::BUF_DEPTH);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b10,
    ST_DROP = 2'b11
  } usbf_state_t;

  // ==========================================================
  // registers
  logic [7:0]    gctl_reg;
  logic [7:0]    attach_reg;
  logic [7:0]    epen_reg;
  logic [15:0]   isocfg_reg;
  logic [7:0]    tx_mem [usbf_pkg::BUF_DEPTH];
  logic [7:0]    rx_mem [usbf_pkg::BUF_DEPTH];
  logic [PW-1:0] tx_cnt_reg;
  logic [PW-1:0] tx_rd_reg;
  logic [PW-1:0] rx_wr_reg;
  logic [PW-1:0] rx_rd_reg;
  logic          rx_full_reg;
  logic          rx_err_reg;
  logic          rx_bad_reg;
  logic          rx_acc_err_reg;
  logic          reject_reg;
  logic          suspended_reg;
  logic          reset_pend_reg;
  logic          bus_reset_d_reg;
  logic [18:0]   idle_cnt_reg;
  logic [4:0]    sof_cnt_reg;
  usbf_state_t   state_reg;
  usbf_state_t   state_next;
  logic [4:0]    ep_in_en;
  logic [4:0]    ep_out_en;

  // ==========================================================
  // decode
  logic       enabled;
  logic       setup_ph;
  logic       access;
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic [3:0] iso_ep;
  logic [7:0] maxp;
  logic       iso_tok;
  logic       in_go;
  logic       out_go;
  logic       rx_end;
  logic       over_size;

  assign enabled  = gctl_reg[usbf_pkg::GCTL_CLK_EN]
                  & gctl_reg[usbf_pkg::GCTL_BLK_EN];
  assign setup_ph = psel & ~penable;
  assign access   = psel & penable;
  assign wr_acc   = access & pwrite;
  assign rd_acc   = access & ~pwrite;
  assign iso_ep   = isocfg_reg[3:0];
  assign maxp     = isocfg_reg[15:8];
  // zero wait states: every access completes in its first access cycle
  assign pready   = access;

  always_comb
  begin
    unique case (paddr)
      usbf_pkg::OFS_GCTL, usbf_pkg::OFS_ATTACH, usbf_pkg::OFS_EPEN,
      usbf_pkg::OFS_ISOCFG, usbf_pkg::OFS_STAT, usbf_pkg::OFS_TXDATA,
      usbf_pkg::OFS_RXDATA, usbf_pkg::OFS_RXCNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // endpoint 0 hard-wired on, endpoints 1-4 from their enable bits
  assign ep_in_en[0]  = 1'b1;
  assign ep_out_en[0] = 1'b1;
  generate
    for (genvar i = 1; i < 5; i++)
    begin : g_ep
      assign ep_in_en[i]  = epen_reg[i-1];
      assign ep_out_en[i] = epen_reg[i+3];
    end
  endgenerate

  // token acceptance; corrupted IN tokens never start a transfer, corrupted OUT tokens go to the drop state
  assign iso_tok = enabled & token.valid & (token.ep == iso_ep)
                 & (iso_ep < 4'h5) & (state_reg == ST_IDLE);
  assign in_go   = iso_tok & token.ok & (token.kind == usbf_pkg::TK_IN)
                 & ep_in_en[iso_ep[2:0]];
  assign out_go  = iso_tok & (token.kind == usbf_pkg::TK_OUT)
                 & ep_out_en[iso_ep[2:0]];
  assign rx_end  = rx.valid & rx.last;
  assign over_size = (8'(rx_wr_reg) >= maxp)
                   | (rx_wr_reg >= DEPTH);

  // ==========================================================
  // transfer state machine
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (in_go)
          state_next = ST_SEND;
        else if (out_go && token.ok)
          state_next = ST_RECV;
        else if (out_go)
          state_next = ST_DROP;
      end
      // no handshake phase: straight back to idle after the packet
      ST_SEND:
      begin
        if (tx.valid && tx_ready && tx.last)
          state_next = ST_IDLE;
      end
      ST_RECV, ST_DROP:
      begin
        if (rx_end)
          state_next = ST_IDLE;
      end
    endcase
    if (bus_reset)
      state_next = ST_IDLE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ==========================================================
  // control registers; usb bus reset deliberately not wired in here
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      gctl_reg <= usbf_pkg::GCTL_RST;
    else if (wr_acc && paddr == usbf_pkg::OFS_GCTL)
      gctl_reg <= pwdata[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      attach_reg <= usbf_pkg::ATTACH_RST;
      epen_reg   <= usbf_pkg::EPEN_RST;
      isocfg_reg <= usbf_pkg::ISOCFG_RST;
    end
    else if (wr_acc)
    begin
      if (paddr == usbf_pkg::OFS_ATTACH)
        attach_reg <= pwdata[7:0];
      if (paddr == usbf_pkg::OFS_EPEN)
        epen_reg <= pwdata[7:0];
      if (paddr == usbf_pkg::OFS_ISOCFG)
        isocfg_reg <= pwdata[15:0];
    end
  end

  // ==========================================================
  // transmit buffer: software fills while not sending, link drains on IN
  always_ff @(posedge clk_sys)
  begin
    if (wr_acc && paddr == usbf_pkg::OFS_TXDATA
        && state_reg != ST_SEND && tx_cnt_reg < DEPTH)
      tx_mem[tx_cnt_reg[PW-2:0]] <= pwdata[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || bus_reset)
      tx_cnt_reg <= '0;
    else if (state_reg == ST_SEND && tx.valid && tx_ready && tx.last)
      tx_cnt_reg <= '0;
    else if (wr_acc && paddr == usbf_pkg::OFS_TXDATA
             && state_reg != ST_SEND && tx_cnt_reg < DEPTH)
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
  end

  // output beat held in flops until the serializer takes it
  always_ff @(posedge clk_sys)
  begin
    if (srst || bus_reset)
    begin
      tx        <= '0;
      tx_rd_reg <= '0;
    end
    else if (in_go)
    begin
      tx.valid  <= 1'b1;
      tx.pid    <= usbf_pkg::PID_DATA0;
      tx.data   <= tx_mem[0];
      tx.last   <= (tx_cnt_reg <= 1);
      tx.zlp    <= (tx_cnt_reg == 0);
      tx_rd_reg <= PW'(1);
    end
    else if (tx.valid && tx_ready)
    begin
      if (tx.last)
        tx.valid <= 1'b0;
      else
      begin
        tx.data   <= tx_mem[tx_rd_reg[PW-2:0]];
        tx.last   <= (tx_rd_reg == tx_cnt_reg - 1'b1);
        tx_rd_reg <= tx_rd_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // receive buffer: one packet, released by writing the count
  always_ff @(posedge clk_sys)
  begin
    if (state_reg == ST_RECV && rx.valid && !rx.last && !over_size
        && !rx_bad_reg)
      rx_mem[rx_wr_reg[PW-2:0]] <= rx.data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || bus_reset)
    begin
      rx_wr_reg      <= '0;
      rx_rd_reg      <= '0;
      rx_full_reg    <= 1'b0;
      rx_bad_reg     <= 1'b0;
      rx_acc_err_reg <= 1'b0;
    end
    else if (out_go && token.ok)
    begin
      // a buffer still holding a packet has no room for another
      rx_bad_reg     <= rx_full_reg;
      rx_acc_err_reg <= 1'b0;
      if (!rx_full_reg)
        rx_wr_reg <= '0;
    end
    else if (state_reg == ST_RECV && rx.valid)
    begin
      if (rx.err || rx.pid != usbf_pkg::PID_DATA0)
        rx_acc_err_reg <= 1'b1;
      if (!rx.last && over_size)
        rx_bad_reg <= 1'b1;
      else if (!rx.last && !rx_bad_reg)
        rx_wr_reg <= rx_wr_reg + 1'b1;
      if (rx.last && !rx_bad_reg)
      begin
        rx_full_reg <= 1'b1;
        rx_rd_reg   <= '0;
      end
      else if (rx.last && !rx_full_reg)
        rx_wr_reg <= '0;
    end
    else if (wr_acc && paddr == usbf_pkg::OFS_RXCNT)
    begin
      rx_full_reg <= 1'b0;
      rx_wr_reg   <= '0;
      rx_rd_reg   <= '0;
    end
    else if (rd_acc && paddr == usbf_pkg::OFS_RXDATA
             && rx_rd_reg < rx_wr_reg)
      rx_rd_reg <= rx_rd_reg + 1'b1;
  end

  // status flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rx_err_reg <= 1'b0;
      reject_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_RECV && rx_end && !rx_bad_reg)
        rx_err_reg <= rx_acc_err_reg | rx.err;
      if (state_reg == ST_RECV && rx_end && rx_bad_reg)
        reject_reg <= 1'b1;
      else if (wr_acc && paddr == usbf_pkg::OFS_STAT
               && pwdata[usbf_pkg::ST_REJECT])
        reject_reg <= 1'b0;
    end
  end

  // ==========================================================
  // suspend detect and event ordering; events plus the suspended flag, no other device state
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      idle_cnt_reg    <= '0;
      suspended_reg   <= 1'b0;
      reset_pend_reg  <= 1'b0;
      bus_reset_d_reg <= 1'b0;
      evt_suspend     <= 1'b0;
      evt_resume      <= 1'b0;
      evt_bus_reset   <= 1'b0;
    end
    else
    begin
      bus_reset_d_reg <= bus_reset;
      evt_suspend     <= 1'b0;
      evt_resume      <= 1'b0;
      evt_bus_reset   <= 1'b0;
      if (!enabled || bus_active || bus_reset)
        idle_cnt_reg <= '0;
      else if (idle_cnt_reg != 19'(SUSP_CYCLES))
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      if (enabled && !suspended_reg && !bus_active && !bus_reset
          && idle_cnt_reg == 19'(SUSP_CYCLES - 1))
      begin
        suspended_reg <= 1'b1;
        evt_suspend   <= 1'b1;
      end
      else if (suspended_reg && (bus_active || bus_reset))
      begin
        suspended_reg  <= 1'b0;
        evt_resume     <= 1'b1;
        reset_pend_reg <= bus_reset & ~bus_reset_d_reg;
      end
      else if (reset_pend_reg)
      begin
        reset_pend_reg <= 1'b0;
        evt_bus_reset  <= 1'b1;
      end
      else if (enabled && bus_reset && !bus_reset_d_reg)
        evt_bus_reset <= 1'b1;
    end
  end

  // ==========================================================
  // start-of-frame pulse counter, retriggered by each uncorrupted sof token
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sof_cnt_reg <= '0;
    else if (enabled && token.valid && token.ok
             && token.kind == usbf_pkg::TK_SOF)
      sof_cnt_reg <= 5'(usbf_pkg::SOF_CYC);
    else if (sof_cnt_reg != 0)
      sof_cnt_reg <= sof_cnt_reg - 1'b1;
  end

  // pins: frame pulse and pull-up supply, or plain port function
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      frame_pulse_pin_o    <= 1'b1;
      frame_pulse_pin_oe   <= 1'b0;
      pullup_supply_pin_o  <= 1'b0;
      pullup_supply_pin_oe <= 1'b0;
      vbus_present         <= 1'b0;
    end
    else
    begin
      if (gctl_reg[usbf_pkg::GCTL_SOF_SEL])
      begin
        frame_pulse_pin_o  <= (sof_cnt_reg == 0);
        frame_pulse_pin_oe <= 1'b1;
      end
      else
      begin
        frame_pulse_pin_o  <= frame_gpio_o;
        frame_pulse_pin_oe <= frame_gpio_oe;
      end
      if (attach_reg[usbf_pkg::ATT_PU_MODE])
      begin
        // supply switched by attach, forcing detach without the cable
        pullup_supply_pin_o  <= attach_reg[usbf_pkg::ATT_ATTACH];
        pullup_supply_pin_oe <= 1'b1;
      end
      else
      begin
        pullup_supply_pin_o  <= pullup_gpio_o;
        pullup_supply_pin_oe <= pullup_gpio_oe;
      end
      vbus_present <= attach_reg[usbf_pkg::ATT_VBUS_EN]
                    & bus_power_sense_pin;
    end
  end

  // ==========================================================
  // apb read data captured in setup so it comes from flops
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      pslverr <= ~mapped;
      prdata  <= '0;
      unique case (paddr)
        usbf_pkg::OFS_GCTL:   prdata[7:0]  <= gctl_reg;
        usbf_pkg::OFS_ATTACH: prdata[7:0]  <= attach_reg;
        usbf_pkg::OFS_EPEN:   prdata[7:0]  <= epen_reg;
        usbf_pkg::OFS_ISOCFG: prdata[15:0] <= isocfg_reg;
        usbf_pkg::OFS_STAT:
        begin
          prdata[usbf_pkg::ST_RX_FULL] <= rx_full_reg;
          prdata[usbf_pkg::ST_RX_ERR]  <= rx_err_reg;
          prdata[usbf_pkg::ST_REJECT]  <= reject_reg;
          prdata[usbf_pkg::ST_SUSPEND] <= suspended_reg;
          prdata[usbf_pkg::ST_TX_BUSY] <= (state_reg == ST_SEND);
          prdata[usbf_pkg::ST_VBUS]    <= vbus_present;
        end
        usbf_pkg::OFS_TXDATA: prdata[PW-1:0] <= tx_cnt_reg;
        usbf_pkg::OFS_RXDATA: prdata[7:0] <= rx_mem[rx_rd_reg[PW-2:0]];
        usbf_pkg::OFS_RXCNT:  prdata[PW-1:0] <= rx_wr_reg;
        default:              prdata <= '0;
      endcase
    end
  end
endmodule

/* File: shared/usbf_pkg.sv */
package usbf_pkg;
  // ==========================================================
  // register byte addresses on the apb slave
  localparam logic [7:0] OFS_GCTL   = 8'h00;
  localparam logic [7:0] OFS_ATTACH = 8'h04;
  localparam logic [7:0] OFS_EPEN   = 8'h08;
  localparam logic [7:0] OFS_ISOCFG = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_TXDATA = 8'h14;
  localparam logic [7:0] OFS_RXDATA = 8'h18;
  localparam logic [7:0] OFS_RXCNT  = 8'h1C;

  // ==========================================================
  // field positions
  localparam int GCTL_CLK_EN  = 5;
  localparam int GCTL_SOF_SEL = 6;
  localparam int GCTL_BLK_EN  = 7;
  localparam int ATT_PU_MODE  = 0;
  localparam int ATT_ATTACH   = 1;
  localparam int ATT_VBUS_EN  = 7;
  localparam int ST_RX_FULL   = 0;
  localparam int ST_RX_ERR    = 1;
  localparam int ST_REJECT    = 2;
  localparam int ST_SUSPEND   = 3;
  localparam int ST_TX_BUSY   = 4;
  localparam int ST_VBUS      = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0]  GCTL_RST   = 8'h00;
  localparam logic [7:0]  ATTACH_RST = 8'h00;
  localparam logic [7:0]  EPEN_RST   = 8'h00;
  localparam logic [15:0] ISOCFG_RST = 16'h4001;

  // ==========================================================
  // buffers, pids, timing
  localparam int         BUF_DEPTH = 64;
  localparam logic [7:0] PID_DATA0 = 8'hC3;
  localparam int         CLK_MHZ   = 100;
  localparam int         SUSP_US   = 3000;
  localparam int         SUSP_CYC  = SUSP_US * CLK_MHZ;
  localparam int         SOF_NS    = 166;
  localparam int         SOF_CYC   = (SOF_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    TK_OUT   = 2'h0,
    TK_IN    = 2'h1,
    TK_SOF   = 2'h2,
    TK_SETUP = 2'h3
  } usbf_tk_kind_t;

  typedef struct packed {
    logic          valid;
    usbf_tk_kind_t kind;
    logic [3:0]    ep;
    logic          ok;
  } usbf_token_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] pid;
    logic [7:0] data;
    logic       last;
    logic       err;
  } usbf_rx_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] pid;
    logic [7:0] data;
    logic       last;
    logic       zlp;
  } usbf_tx_t;
endpackage

/* File: verification/usbf_assertions.sv */
// ==========================================================
// port checker for the iso/control block
module usbf_chk #(
  parameter int SUSP_CYCLES = 50
) (
  input wire logic                  clk_sys,
  input wire logic                  srst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [7:0]            paddr,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire usbf_pkg::usbf_token_t token,
  input wire usbf_pkg::usbf_tx_t    tx,
  input wire logic                  tx_ready,
  input wire logic                  bus_active,
  input wire logic                  bus_reset,
  input wire logic                  evt_suspend,
  input wire logic                  evt_resume,
  input wire logic                  evt_bus_reset,
  input wire logic                  frame_pulse_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   idle_cnt;
  int   low_cnt;
  logic susp_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  // idle span, pulse width and suspend tracking
  always_ff @(posedge clk_sys)
  begin
    if (srst || bus_active || bus_reset)
      idle_cnt <= 0;
    else if (idle_cnt < SUSP_CYCLES + 2)
      idle_cnt <= idle_cnt + 1; // saturate, only the threshold matters
    low_cnt <= (srst || frame_pulse_pin_o) ? 0 : low_cnt + 1;
    if (srst || evt_resume)
      susp_q <= 1'b0;
    else if (evt_suspend)
      susp_q <= 1'b1;
  end

  sequence s_wake_then_reset;
    evt_resume ##1 evt_bus_reset;
  endsequence

  a_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_unmapped_err: assert property (psel && !penable &&
    paddr > usbf_pkg::OFS_RXCNT |=> pslverr)
    else $error("unmapped access not refused");
  a_tx_data0_pid: assert property (
    tx.valid |-> tx.pid == usbf_pkg::PID_DATA0)
    else $error("iso beat without data0 pid");
  a_tx_hold_stall: assert property (
    tx.valid && !tx_ready |=> tx.valid && $stable(tx))
    else $error("beat changed while stalled");
  a_no_handshake: assert property (
    tx.valid && tx.last && tx_ready && !token.valid |=> !tx.valid)
    else $error("sender not idle after last beat");
  a_bad_in_silent: assert property (
    token.valid && !token.ok && token.kind == usbf_pkg::TK_IN
    && !tx.valid |=> !tx.valid)
    else $error("answer to corrupted token");
  a_zlp_is_last: assert property (
    tx.valid && tx.zlp |-> tx.last)
    else $error("zero-length beat not last");
  a_suspend_idle: assert property (
    evt_suspend |-> idle_cnt >= SUSP_CYCLES - 1)
    else $error("suspend before idle span");
  a_wake_first: assert property (
    susp_q && $rose(bus_reset) |=> s_wake_then_reset)
    else $error("bus reset not after resume");
  a_sof_width: assert property (
    $rose(frame_pulse_pin_o) |-> low_cnt == usbf_pkg::SOF_CYC)
    else $error("frame pulse width wrong");
endmodule

bind usbf_iso_ctrl usbf_chk #(.SUSP_CYCLES(SUSP_CYCLES)) u_chk (
  .clk_sys, .srst, .psel, .penable, .paddr, .pready, .pslverr, .token,
  .tx, .tx_ready, .bus_active, .bus_reset, .evt_suspend, .evt_resume,
  .evt_bus_reset, .frame_pulse_pin_o
);

/* File: verification/usbf_iso_ctrl_tb_top.sv */
// ==========================================================
// bench top
module usbf_iso_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 50;
  logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, tx_ready, slow = 0, bus_active = 1;
  logic bus_reset = 0, evt_suspend, evt_resume, evt_bus_reset, vb = 0;
  logic fp_o, fp_oe, pu_o, pu_oe, vbus_present;
  usbf_pkg::usbf_token_t token = '0;
  usbf_pkg::usbf_rx_t rx = '0;
  usbf_pkg::usbf_tx_t tx;
  int n_mismatch = 0, n_checks = 0;
  longint t_res, t_rst, t_sus, t_idle;
  logic [7:0] av[3] = '{8'h80, 8'h81, 8'h83};

  usbf_iso_ctrl #(.SUSP_CYCLES(SC)) dut (.clk_sys, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .token, .rx, .tx, .tx_ready, .bus_active, .bus_reset, .evt_suspend,
    .evt_resume, .evt_bus_reset, .frame_gpio_o(1'b1),
    .frame_gpio_oe(1'b0), .frame_pulse_pin_o(fp_o),
    .frame_pulse_pin_oe(fp_oe), .pullup_gpio_o(1'b1),
    .pullup_gpio_oe(1'b0), .pullup_supply_pin_o(pu_o),
    .pullup_supply_pin_oe(pu_oe), .bus_power_sense_pin(vb),
    .vbus_present);
  usbf_serial_model host (.clk_sys, .srst, .tx, .slow, .tx_ready);

  always #5 clk_sys = ~clk_sys;

  // event timestamps for ordering checks
  always @(posedge clk_sys)
  begin
    if (evt_suspend === 1'b1) t_sus = $time;
    if (evt_resume === 1'b1) t_res = $time;
    if (evt_bus_reset === 1'b1) t_rst = $time;
  end

  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, x, g);
    end
  endtask

  // one apb transfer, held until pready at a rising edge
  // only the watchdog ends the wait; one idle edge keeps calls apart
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] x);
    apb(0, a, 0);
    chk("reg", x, q);
  endtask

  task automatic tok(usbf_pkg::usbf_tk_kind_t k, logic ok);
    token <= '{1'b1, k, 4'h1, ok};
    @(posedge clk_sys);
    token <= '0;
  endtask

  // iso out packet: n data beats then the end beat
  task automatic outpkt(logic ok, int n, logic er);
    tok(usbf_pkg::TK_OUT, ok);
    for (int i = 0; i <= n; i++)
    begin
      rx <= '{1'b1, usbf_pkg::PID_DATA0, 8'h10 + i[7:0], i == n, er && i == n};
      @(posedge clk_sys);
    end
    rx <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic intx(logic ok, logic s);
    host.q.delete();
    slow <= s;
    tok(usbf_pkg::TK_IN, ok);
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog: the whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 0;
    @(posedge clk_sys);
    rd(usbf_pkg::OFS_GCTL, 32'(usbf_pkg::GCTL_RST));
    rd(usbf_pkg::OFS_EPEN, 32'(usbf_pkg::EPEN_RST));
    rd(usbf_pkg::OFS_ISOCFG, 32'(usbf_pkg::ISOCFG_RST));
    rd(8'h40, 32'h0);
    chk("slverr", 1, e);
    apb(1, usbf_pkg::OFS_GCTL, 32'h20);
    apb(1, usbf_pkg::OFS_GCTL, 32'hE0);
    repeat (25) @(posedge clk_sys);
    vb <= 1;
    // port pin passes through in mode 0, supply switch in mode 1
    foreach (av[i])
    begin
      apb(1, usbf_pkg::OFS_ATTACH, 32'(av[i]));
      repeat (3) @(posedge clk_sys);
      chk("pullup", i != 1, pu_o);
      chk("pu oe", i != 0, pu_oe);
    end
    chk("vbus", 1, vbus_present);
    apb(1, usbf_pkg::OFS_EPEN, 32'h11);
    rd(usbf_pkg::OFS_EPEN, 32'h11);
    apb(1, usbf_pkg::OFS_TXDATA, 32'hA5);
    apb(1, usbf_pkg::OFS_TXDATA, 32'h5A);
    intx(1, 1);
    chk("beats", 2, host.q.size());
    chk("b0", {2'b00, usbf_pkg::PID_DATA0, 8'hA5}, host.q[0]);
    chk("b1", {2'b10, usbf_pkg::PID_DATA0, 8'h5A}, host.q[1]);
    intx(1, 0);
    chk("zlp", 2'b11, host.q[0][17:16]);
    apb(1, usbf_pkg::OFS_TXDATA, 32'h77);
    intx(0, 0);
    chk("silent", 0, host.q.size());
    outpkt(1, 3, 0);
    rd(usbf_pkg::OFS_STAT, 32'h21);
    rd(usbf_pkg::OFS_RXDATA, 32'h10);
    // buffer still full: new packet refused, held count unchanged
    outpkt(1, 2, 0);
    rd(usbf_pkg::OFS_RXCNT, 32'h3);
    apb(1, usbf_pkg::OFS_RXCNT, 32'h0);
    apb(1, usbf_pkg::OFS_STAT, 32'h4);
    outpkt(1, 2, 1);
    rd(usbf_pkg::OFS_STAT, 32'h23);
    apb(1, usbf_pkg::OFS_RXCNT, 32'h0);
    outpkt(0, 2, 0);
    rd(usbf_pkg::OFS_RXCNT, 32'h0);
    apb(1, usbf_pkg::OFS_ISOCFG, 32'h0201);
    // rejected packet leaves the error flag of the last stored one
    outpkt(1, 3, 0);
    rd(usbf_pkg::OFS_STAT, 32'h26);
    tok(usbf_pkg::TK_SOF, 1);
    repeat (3) @(posedge clk_sys);
    chk("sof low", 0, fp_o);
    chk("sof oe", 1, fp_oe);
    repeat (20) @(posedge clk_sys);
    chk("sof high", 1, fp_o);
    bus_active <= 0;
    t_idle = $time;
    repeat (SC + 5) @(posedge clk_sys);
    // idle span plus the registered event pulse
    chk("susp", (SC + 1) * 10, 32'(t_sus - t_idle));
    apb(0, usbf_pkg::OFS_STAT, 0);
    chk("suspended", 1, q[usbf_pkg::ST_SUSPEND]);
    bus_reset <= 1;
    repeat (4) @(posedge clk_sys);
    chk("order", 10, 32'(t_rst - t_res));
    bus_reset <= 0;
    bus_active <= 1;
    rd(usbf_pkg::OFS_GCTL, 32'hE0);
    close_out;
  end
endmodule

/* File: verification/usbf_serial_model.sv */
// ==========================================================
// far-side serializer: takes beats, optionally stalls
module usbf_serial_model (
  input wire logic               clk_sys,
  input wire logic               srst,
  input wire usbf_pkg::usbf_tx_t tx,
  input wire logic               slow,
  output logic                   tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] q[$];
  logic        ph = 1'b0;

  // ready every other cycle when slow; never waits for a handshake
  always @(posedge clk_sys)
  begin
    ph <= srst ? 1'b0 : ~ph;
    tx_ready <= !slow || ph;
    if (srst)
      q.delete();
    else if (tx.valid && tx_ready)
      q.push_back({tx.last, tx.zlp, tx.pid, tx.data});
  end
endmodule
